// [rtl/bwtc_ctrl.sv]
// Purpose: Wake input debounce, tamper debouncers and wake sources of a backup supply controller
// Assumes: clk is the slow clock; inputs synchronous to it; AHB-Lite slave, zero wait
// Notes: Core restart is a one-cycle request pulse; password and write protect gate writes
//
// Functional notes
// - Wake input counts only when enabled; active level set by its polarity bit.
// - Enabled, polarity-adjusted wake inputs ORed into one shared debounce counter.
// - Debounce select chooses 3, 32, 512, 4096 or 32768 slow clock cycles.
// - Select zero wakes once an input stays active one slow clock period.
// - Active beyond debounce length starts wakeup and sets per-input source flags.
// - Later wake overwrites sources; no new wake until the condition goes away.
// - Two tamper inputs each own an enabled low-power debouncer able to wake.
// - Tamper detection runs with core powered and raises an interrupt.
// - Debouncers sample on falling edges of the clock waveform output.
// - Tamper wakes after 2 to 8 identical samples; count shared by both.
// - Each tamper input has its own polarity bit.
// - Each tamper debouncer has its own status flag in the status register.
// - Tamper with clear enable clears lower backup half; second input may be excluded.
// - Calendar and timer alarms wake when their enable bits are set.
// - No status flag is kept for alarm wakeups.
// - Supply monitor detection can act as a wake source.
// - Write protect blocks writes to command, monitor, mode and wake mode registers.
// - Any accepted wake event requests the core supply restart sequence.
// - Command and mode writes need password 0xa5, otherwise the write aborts.
//
// The AHB-Lite register port is this design's own decision.
`include "bwtc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module bwtc_ctrl #(
	parameter int NWAKE = 16,
	parameter logic [15:0] DBC_LEN_4 = `BWTC_DBC_LEN_4,
	parameter logic [15:0] DBC_LEN_5 = `BWTC_DBC_LEN_5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire bwtc_pkg::bwtc_ahb_req_t ahb_req,
	input wire logic [31:0] hwdata,
	output bwtc_pkg::bwtc_ahb_rsp_t ahb_rsp,
	input wire logic [NWAKE-1:0] wake_input_pin,
	input wire logic clock_wave_output,
	input wire logic calendar_alarm,
	input wire logic timer_alarm,
	input wire logic monitor_detect,
	output logic core_restart,
	output logic tamper_irq,
	output logic backup_clear_low,
	output logic voltage_reg_off
);
	import bwtc_pkg::*;

	typedef struct packed {
		logic [31:0] monitor_mode;
		logic [31:0] mode;
		logic [31:0] wake_mode;
		logic [31:0] wake_cfg;
		logic wp_en;
		logic [NWAKE-1:0] wake_flags;
		logic [1:0] tamper_flags;
		bwtc_wake_st_t wst;
		logic [15:0] wcnt;
		logic [1:0] tamper_last;
		logic [3:0] tcnt0;
		logic [3:0] tcnt1;
		logic [1:0] tamper_hit;
		logic wave_d;
		logic alarm_d;
		logic ph_wr;
		logic ph_rd;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
		logic restart;
		logic irq;
		logic bclr;
		logic vroff;
	} bwtc_state_t;

	bwtc_state_t st;
	bwtc_state_t next_st;

	logic [NWAKE-1:0] wake_active;
	logic wake_any;
	logic [15:0] dbc_len;
	logic [3:0] tamper_need;
	logic sample;
	logic [1:0] tamper_lvl;
	logic [1:0] tamper_new;
	logic alarm_now;
	logic key_ok;
	logic addr_ok;

	// ==========================================================
	// Wake input conditioning
	always_comb begin
		wake_active = (wake_input_pin ^ st.wake_cfg[16 +: NWAKE]) & st.wake_cfg[NWAKE-1:0];
		wake_any = |wake_active;
		case (st.wake_mode[`BWTC_WM_WAKE_DBC_MSB:`BWTC_WM_WAKE_DBC_LSB])
			3'h1: dbc_len = `BWTC_DBC_LEN_1;
			3'h2: dbc_len = `BWTC_DBC_LEN_2;
			3'h3: dbc_len = `BWTC_DBC_LEN_3;
			3'h4: dbc_len = DBC_LEN_4;
			3'h5: dbc_len = DBC_LEN_5;
			default: dbc_len = 16'h0001;
		endcase
		tamper_need = {1'b0, st.wake_mode[`BWTC_WM_TAMPER_CNT_MSB:`BWTC_WM_TAMPER_CNT_LSB]}
			+ `BWTC_TAMPER_CNT_MIN;
		if (tamper_need > 4'h8) begin
			tamper_need = 4'h8;
		end
		sample = st.wave_d & ~clock_wave_output;
		tamper_lvl[0] = wake_input_pin[0] ^ st.wake_cfg[16];
		tamper_lvl[1] = wake_input_pin[NWAKE > 10 ? 10 : 1] ^ st.wake_cfg[NWAKE > 10 ? 26 : 17];
		alarm_now = (calendar_alarm & st.wake_mode[`BWTC_WM_CAL_ALARM_WAKE_EN])
			| (timer_alarm & st.wake_mode[`BWTC_WM_TIMER_ALARM_WAKE_EN])
			| (monitor_detect & st.wake_mode[`BWTC_WM_MONITOR_WAKE_EN]);
		key_ok = hwdata[`BWTC_KEY_MSB:`BWTC_KEY_LSB] == `BWTC_PASSWORD;
		addr_ok = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.restart = 1'b0;
		next_st.irq = 1'b0;
		next_st.bclr = 1'b0;
		next_st.vroff = 1'b0;
		next_st.wave_d = clock_wave_output;
		next_st.alarm_d = alarm_now;
		tamper_new = 2'b00;

		// Shared wake debounce
		case (st.wst)
			BWTC_WAKE_IDLE: begin
				next_st.wcnt = 16'h0000;
				if (wake_any) begin
					next_st.wst = BWTC_WAKE_COUNT;
					next_st.wcnt = 16'h0001;
				end
			end
			BWTC_WAKE_COUNT: begin
				if (!wake_any) begin
					next_st.wst = BWTC_WAKE_IDLE;
					next_st.wcnt = 16'h0000;
				end else if (st.wcnt >= dbc_len) begin
					next_st.wst = BWTC_WAKE_HELD;
					next_st.wake_flags = wake_active;
					next_st.restart = 1'b1;
				end else begin
					next_st.wcnt = st.wcnt + 16'h0001;
				end
			end
			BWTC_WAKE_HELD: begin
				// Rearm only after the condition fully drops
				if (!wake_any) begin
					next_st.wst = BWTC_WAKE_IDLE;
				end
			end
			default: next_st.wst = BWTC_WAKE_IDLE;
		endcase

		// Tamper debouncers, one per input
		if (sample) begin
			next_st.tamper_last = tamper_lvl;
			next_st.tcnt0 = (tamper_lvl[0] == st.tamper_last[0] && st.tcnt0 != 4'hf)
				? st.tcnt0 + 4'h1 : 4'h1;
			next_st.tcnt1 = (tamper_lvl[1] == st.tamper_last[1] && st.tcnt1 != 4'hf)
				? st.tcnt1 + 4'h1 : 4'h1;
			tamper_new[0] = st.wake_mode[`BWTC_WM_TAMPER0_DBC_EN] & tamper_lvl[0]
				& next_st.tcnt0 == tamper_need & ~st.tamper_hit[0];
			tamper_new[1] = st.wake_mode[`BWTC_WM_TAMPER1_DBC_EN] & tamper_lvl[1]
				& next_st.tcnt1 == tamper_need & ~st.tamper_hit[1];
			next_st.tamper_hit[0] = tamper_lvl[0] & (st.tamper_hit[0] | tamper_new[0]);
			next_st.tamper_hit[1] = tamper_lvl[1] & (st.tamper_hit[1] | tamper_new[1]);
		end
		if (|tamper_new) begin
			next_st.restart = 1'b1;
			next_st.irq = 1'b1;
			next_st.bclr = st.wake_mode[`BWTC_WM_TAMPER_CLR_EN] & (tamper_new[0]
				| (tamper_new[1] & ~st.wake_mode[`BWTC_WM_TAMPER1_CLR_DIS]));
		end
		// Alarms wake with no flag of their own
		if (alarm_now & ~st.alarm_d) begin
			next_st.restart = 1'b1;
		end

		// AHB data phase
		next_st.ph_wr = addr_ok & ahb_req.hwrite;
		next_st.ph_rd = addr_ok & ~ahb_req.hwrite;
		next_st.ph_addr = ahb_req.haddr[7:0];
		if (st.ph_wr) begin
			case (st.ph_addr)
				`BWTC_OFS_SUPPLY_COMMAND: begin
					if (!st.wp_en && key_ok) begin
						next_st.vroff = hwdata[2];
					end
				end
				`BWTC_OFS_SUPPLY_MONITOR_MODE: begin
					if (!st.wp_en) begin
						next_st.monitor_mode = hwdata & 32'h0000_370f;
					end
				end
				`BWTC_OFS_SUPPLY_MODE: begin
					if (!st.wp_en && key_ok) begin
						next_st.mode = hwdata & 32'h0010_f03f;
					end
				end
				`BWTC_OFS_WAKE_MODE: begin
					if (!st.wp_en) begin
						next_st.wake_mode = hwdata & 32'h1107_77ef;
					end
				end
				`BWTC_OFS_WAKE_INPUTS_CONFIG: begin
					next_st.wake_cfg = hwdata;
				end
				`BWTC_OFS_WRITE_PROTECT: begin
					next_st.wp_en = hwdata[`BWTC_WP_ENABLE];
				end
				default: begin
				end
			endcase
		end
		// Read of status clears tamper flags; a new event in the same cycle wins
		if (st.ph_rd && st.ph_addr == `BWTC_OFS_SUPPLY_STATUS) begin
			next_st.tamper_flags = 2'b00;
		end
		next_st.tamper_flags = next_st.tamper_flags | tamper_new;
		if (next_st.ph_rd) begin
			case (ahb_req.haddr[7:0])
				`BWTC_OFS_SUPPLY_MONITOR_MODE: next_st.rdata = st.monitor_mode;
				`BWTC_OFS_SUPPLY_MODE: next_st.rdata = st.mode;
				`BWTC_OFS_WAKE_MODE: next_st.rdata = st.wake_mode;
				`BWTC_OFS_WAKE_INPUTS_CONFIG: next_st.rdata = st.wake_cfg;
				`BWTC_OFS_SUPPLY_STATUS: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rdata[`BWTC_SR_TAMPER0_FLAG] = st.tamper_flags[0];
					next_st.rdata[`BWTC_SR_TAMPER1_FLAG] = st.tamper_flags[1];
					next_st.rdata[`BWTC_SR_WAKE_FLAG_LSB +: NWAKE] = st.wake_flags;
				end
				`BWTC_OFS_WRITE_PROTECT: next_st.rdata = {31'h0, st.wp_en};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.monitor_mode <= `BWTC_RST_SUPPLY_MONITOR_MODE;
			st.mode <= `BWTC_RST_SUPPLY_MODE;
			st.wake_mode <= `BWTC_RST_WAKE_MODE;
			st.wake_cfg <= `BWTC_RST_WAKE_INPUTS_CONFIG;
			st.wst <= BWTC_WAKE_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		ahb_rsp.hrdata = st.rdata;
		ahb_rsp.hreadyout = 1'b1;
		ahb_rsp.hresp = 1'b0;
		core_restart = st.restart;
		tamper_irq = st.irq;
		backup_clear_low = st.bclr;
		voltage_reg_off = st.vroff;
	end

	// ==========================================================
	// Checks
	sequence s_wake_held;
		wake_any && st.wst == BWTC_WAKE_COUNT && st.wcnt >= dbc_len;
	endsequence

	a_wake_mask_off: assert property (@(posedge clk) disable iff (!rst_n)
		st.wake_cfg[NWAKE-1:0] == '0 |-> !wake_any) else $error("disabled wake input active");
	a_wake_or: assert property (@(posedge clk) disable iff (!rst_n)
		(st.wst == BWTC_WAKE_IDLE && wake_any) |=> st.wst == BWTC_WAKE_COUNT)
		else $error("combined wake did not start counter");
	a_dbc_three: assert property (@(posedge clk) disable iff (!rst_n)
		st.wake_mode[14:12] == 3'h1 |-> dbc_len == 16'd3) else $error("wrong debounce length");
	a_dbc_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(st.wake_mode[14:12] == 3'h0 && st.wst == BWTC_WAKE_IDLE && wake_any) ##1 wake_any
		|=> core_restart) else $error("immediate wake missing");
	a_wake_flags: assert property (@(posedge clk) disable iff (!rst_n)
		s_wake_held |=> core_restart && st.wake_flags == $past(wake_active))
		else $error("wake flags or restart wrong");
	a_no_rewake: assert property (@(posedge clk) disable iff (!rst_n)
		st.wst == BWTC_WAKE_HELD |=> !core_restart || !$past(wake_any) || $past(alarm_now)
		|| $past(|tamper_new)) else $error("rewake while held");
	a_count_restart: assert property (@(posedge clk) disable iff (!rst_n)
		(st.wst == BWTC_WAKE_COUNT && !wake_any) |=> st.wcnt == 16'h0000)
		else $error("counter not restarted");
	a_tamper_irq: assert property (@(posedge clk) disable iff (!rst_n)
		|tamper_new |=> tamper_irq && core_restart) else $error("tamper irq missing");
	a_tamper_flag: assert property (@(posedge clk) disable iff (!rst_n)
		tamper_new[1] |=> st.tamper_flags[1]) else $error("tamper flag lost");
	a_tamper_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(tamper_new[1] && !tamper_new[0] && st.wake_mode[24]) |=> !backup_clear_low)
		else $error("clear not suppressed");
	a_sample_only: assert property (@(posedge clk) disable iff (!rst_n)
		!sample |=> st.tcnt0 == $past(st.tcnt0)) else $error("sample off edge");
	a_protect: assert property (@(posedge clk) disable iff (!rst_n)
		(st.ph_wr && st.wp_en) |=> st.wake_mode == $past(st.wake_mode))
		else $error("protected write took effect");
	a_password: assert property (@(posedge clk) disable iff (!rst_n)
		(st.ph_wr && st.ph_addr == 8'h08 && !key_ok) |=> st.mode == $past(st.mode))
		else $error("bad password accepted");
	a_alarm_wake: assert property (@(posedge clk) disable iff (!rst_n)
		(alarm_now && !st.alarm_d) |=> core_restart) else $error("alarm wake missing");
endmodule // bwtc_ctrl

`default_nettype wire

// [rtl/bwtc_map.svh]
// Purpose: Register offsets, field positions, reset values and counts of the wake/tamper block
// Assumes: AHB-Lite word registers, byte offsets as printed
// Notes: Definitions only
`ifndef BWTC_MAP_SVH
`define BWTC_MAP_SVH

// ==========================================================
// Register offsets
`define BWTC_OFS_SUPPLY_COMMAND 8'h00
`define BWTC_OFS_SUPPLY_MONITOR_MODE 8'h04
`define BWTC_OFS_SUPPLY_MODE 8'h08
`define BWTC_OFS_WAKE_MODE 8'h0c
`define BWTC_OFS_WAKE_INPUTS_CONFIG 8'h10
`define BWTC_OFS_SUPPLY_STATUS 8'h14
`define BWTC_OFS_WRITE_PROTECT 8'h18

// ==========================================================
// Reset values
`define BWTC_RST_SUPPLY_MONITOR_MODE 32'h0000_0000
`define BWTC_RST_SUPPLY_MODE 32'h0000_da00
`define BWTC_RST_WAKE_MODE 32'h0000_0000
`define BWTC_RST_WAKE_INPUTS_CONFIG 32'h0000_0000

// ==========================================================
// Field positions
`define BWTC_KEY_MSB 31
`define BWTC_KEY_LSB 24
`define BWTC_PASSWORD 8'ha5
`define BWTC_WM_MONITOR_WAKE_EN 1
`define BWTC_WM_TIMER_ALARM_WAKE_EN 2
`define BWTC_WM_CAL_ALARM_WAKE_EN 3
`define BWTC_WM_TAMPER0_DBC_EN 5
`define BWTC_WM_TAMPER1_DBC_EN 6
`define BWTC_WM_TAMPER_CLR_EN 7
`define BWTC_WM_WAKE_DBC_MSB 14
`define BWTC_WM_WAKE_DBC_LSB 12
`define BWTC_WM_TAMPER_CNT_MSB 18
`define BWTC_WM_TAMPER_CNT_LSB 16
`define BWTC_WM_TAMPER1_CLR_DIS 24
`define BWTC_SR_TAMPER0_FLAG 13
`define BWTC_SR_TAMPER1_FLAG 14
`define BWTC_SR_WAKE_FLAG_LSB 16
`define BWTC_WP_ENABLE 0

// ==========================================================
// Debounce lengths in slow clock cycles
`define BWTC_DBC_LEN_1 16'd3
`define BWTC_DBC_LEN_2 16'd32
`define BWTC_DBC_LEN_3 16'd512
`define BWTC_DBC_LEN_4 16'd4096
`define BWTC_DBC_LEN_5 16'd32768
`define BWTC_TAMPER_CNT_MIN 4'd2
`endif

// [rtl/bwtc_pkg.sv]
// Purpose: Types of the wake/tamper block
// Assumes: Included after bwtc_map.svh
// Notes: Types only
`default_nettype none

package bwtc_pkg;
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hsel;
		logic hready;
	} bwtc_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} bwtc_ahb_rsp_t;

	typedef enum logic [1:0] {
		BWTC_WAKE_IDLE = 2'b00,
		BWTC_WAKE_COUNT = 2'b01,
		BWTC_WAKE_HELD = 2'b10
	} bwtc_wake_st_t;
endpackage

`default_nettype wire

// [verif/bwtc_pins.sv]
// Purpose: Wake pins and tamper switches facing the wake/tamper block
// Assumes: Pin levels come from the bench; the sampling wave runs only while run is high
// Notes: Wave period is 8 clk, so the bench has slack between two sample points
`timescale 1ns/100ps
`default_nettype none

module bwtc_pins (
	input wire logic clk,
	input wire logic [15:0] level,
	input wire logic run,
	output logic [15:0] wake_input_pin,
	output logic clock_wave_output,
	output var int falls
);
	logic [2:0] ph;

	// ====
	// Pins and sampling wave
	assign wake_input_pin = level;
	// Wave stands low between runs so that no stray sample point appears
	assign clock_wave_output = run && !ph[2];
	always_ff @(posedge clk) begin
		if (!run) begin
			ph <= 3'h0;
			falls <= 0;
		end else begin
			ph <= ph + 3'h1;
			if (ph == 3'h3) falls <= falls + 1;
		end
	end
endmodule // bwtc_pins
`default_nettype wire

// [verif/tb_backup_wakeup_tamper_control.sv]
// Purpose: Self-checking bench of the wake/tamper block
// Assumes: Zero-wait AHB-Lite slave; long debounce lengths shortened to 8 and 16
// Notes: Pulses are counted on the falling clock edge, away from the sampling edge
`include "bwtc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_backup_wakeup_tamper_control;
	import bwtc_pkg::*;
	localparam logic [15:0] L4 = 16'h8;
	localparam logic [15:0] L5 = 16'h10;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [15:0] level = '0;
	logic run = 1'b0;
	logic [2:0] alm = 3'b000;
	bwtc_ahb_req_t req;
	bwtc_ahb_rsp_t rsp;
	logic [15:0] pins;
	logic wave, restart, irq, bclr, vroff;
	int falls, k, j, c, f, o0, c0, r0;
	int n_errors = 0;
	int compares = 0;
	int n_rst = 0;
	int n_irq = 0;
	int n_clr = 0;
	int n_off = 0;
	logic [31:0] q, x, y;
	logic [15:0] polv;

	assign req = '{haddr, htrans, hwrite, 3'b010, 1'b1, rsp.hreadyout};
	always #5 clk = ~clk;

	bwtc_pins pins_u (.clk(clk), .level(level), .run(run), .wake_input_pin(pins),
		.clock_wave_output(wave), .falls(falls));
	bwtc_ctrl #(.DBC_LEN_4(L4), .DBC_LEN_5(L5)) dut_u (.clk(clk), .rst_n(rst_n), .ahb_req(req),
		.hwdata(hwdata), .ahb_rsp(rsp), .wake_input_pin(pins), .clock_wave_output(wave),
		.calendar_alarm(alm[2]), .timer_alarm(alm[1]), .monitor_detect(alm[0]),
		.core_restart(restart), .tamper_irq(irq), .backup_clear_low(bclr),
		.voltage_reg_off(vroff));

	always @(negedge clk) begin
		if (rst_n) begin
			n_rst += restart;
			n_irq += irq;
			n_clr += bclr;
			n_off += vroff;
		end
	end

	// ====
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		q = rsp.hrdata;
		check(rsp.hresp, 1'b0, "bus response");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
		bus(1'b0, a, 32'h0);
		check(q, e, w);
	endtask

	// Edges until a pulse counter moves, or lim when it never does
	task automatic wait_chg(ref int cnt, input int lim, output int n);
		int s;
		s = cnt;
		n = 0;
		while (cnt == s && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	function automatic int dbc_len(input int s);
		case (s)
			0: return 1;
			1: return `BWTC_DBC_LEN_1;
			2: return `BWTC_DBC_LEN_2;
			3: return `BWTC_DBC_LEN_3;
			4: return L4;
			default: return L5;
		endcase
	endfunction

	task automatic final_report();
		if (n_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		final_report();
	end

	// ====
	// Main sequence
	initial begin
		void'($urandom(82487));
		polv = $urandom();
		level = ~polv;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`BWTC_OFS_SUPPLY_MONITOR_MODE, `BWTC_RST_SUPPLY_MONITOR_MODE, "rst monitor");
		rd(`BWTC_OFS_SUPPLY_MODE, `BWTC_RST_SUPPLY_MODE, "rst mode");
		rd(`BWTC_OFS_WAKE_MODE, `BWTC_RST_WAKE_MODE, "rst wake mode");
		rd(`BWTC_OFS_WAKE_INPUTS_CONFIG, `BWTC_RST_WAKE_INPUTS_CONFIG, "rst wake cfg");
		rd(`BWTC_OFS_SUPPLY_STATUS, 32'h0, "rst status");
		rd(8'h20, 32'h0, "unmapped");
		x = $urandom() & 32'h0107_70ee;
		y = $urandom() & 32'h0000_370f;
		wr(`BWTC_OFS_WAKE_MODE, x);
		wr(`BWTC_OFS_SUPPLY_MONITOR_MODE, y);
		rd(`BWTC_OFS_WAKE_MODE, x, "wake mode rw");
		wr(`BWTC_OFS_WRITE_PROTECT, 32'h1);
		wr(`BWTC_OFS_WAKE_MODE, ~x & 32'h0107_70ee);
		wr(`BWTC_OFS_SUPPLY_MONITOR_MODE, ~y & 32'h0000_370f);
		wr(`BWTC_OFS_SUPPLY_MODE, {`BWTC_PASSWORD, 24'h10_5003});
		o0 = n_off;
		wr(`BWTC_OFS_SUPPLY_COMMAND, {`BWTC_PASSWORD, 24'h4});
		rd(`BWTC_OFS_WAKE_MODE, x, "protected wake mode");
		rd(`BWTC_OFS_SUPPLY_MONITOR_MODE, y, "protected monitor");
		rd(`BWTC_OFS_SUPPLY_MODE, `BWTC_RST_SUPPLY_MODE, "protected mode");
		check(n_off - o0, 0, "protected command");
		wr(`BWTC_OFS_WRITE_PROTECT, 32'h0);
		wr(`BWTC_OFS_SUPPLY_MODE, {8'h5a, 24'h10_5003});
		rd(`BWTC_OFS_SUPPLY_MODE, `BWTC_RST_SUPPLY_MODE, "bad key mode");
		wr(`BWTC_OFS_SUPPLY_MODE, {`BWTC_PASSWORD, 24'h10_5003});
		bus(1'b0, `BWTC_OFS_SUPPLY_MODE, 32'h0);
		check(q & 32'h00ff_ffff, 32'h0010_5003, "good key mode");
		// All wake inputs idle here, so a backup request is legal
		wr(`BWTC_OFS_SUPPLY_COMMAND, {8'h5a, 24'h4});
		wr(`BWTC_OFS_SUPPLY_COMMAND, {`BWTC_PASSWORD, 24'h4});
		repeat (2) @(posedge clk);
		check(n_off - o0, 1, "command key");
		for (int s = 0; s < 6; s++) begin
			k = 1 + $urandom_range(0, 8);
			j = 11 + $urandom_range(0, 4);
			// A polarity bit equal to the idle pin level keeps that pin inactive
			wr(`BWTC_OFS_WAKE_INPUTS_CONFIG, {~polv, 16'h1 << k});
			wr(`BWTC_OFS_WAKE_MODE, s << 12);
			level <= ~polv ^ (16'h1 << j);
			wait_chg(n_rst, 40, c);
			check(c, 40, "disabled pin woke");
			if (s > 1) begin
				level <= ~polv ^ (16'h1 << k);
				wait_chg(n_rst, dbc_len(s) / 2, c);
				check(c, dbc_len(s) / 2, "early wake");
				level <= ~polv;
				@(posedge clk);
			end
			level <= ~polv ^ (16'h1 << k);
			wait_chg(n_rst, 600, c);
			check(c >= dbc_len(s) + 1 && c <= dbc_len(s) + 3, 1, "debounce length");
			rd(`BWTC_OFS_SUPPLY_STATUS, {16'h1 << k, 16'h0}, "source flag");
			wait_chg(n_rst, 20, c);
			check(c, 20, "rewake while held");
			level <= ~polv;
			@(posedge clk);
		end
		for (int b = 1; b < 4; b++) begin
			wr(`BWTC_OFS_WAKE_MODE, 32'h0);
			alm <= 3'b001 << (b - 1);
			wait_chg(n_rst, 6, c);
			check(c, 6, "alarm gated");
			alm <= 3'b000;
			wr(`BWTC_OFS_WAKE_MODE, 32'h1 << b);
			alm <= 3'b001 << (b - 1);
			wait_chg(n_rst, 6, c);
			check(c < 6, 1, "alarm wake");
			alm <= 3'b000;
			rd(`BWTC_OFS_SUPPLY_STATUS, {16'h1 << k, 16'h0}, "alarm flag");
		end
		for (int t = 0; t < 2; t++) begin
			f = $urandom_range(0, 6);
			wr(`BWTC_OFS_WAKE_INPUTS_CONFIG, {~polv, 16'h0});
			wr(`BWTC_OFS_WAKE_MODE, 32'h0100_0080 | (f << 16) | (32'h20 << t));
			level <= ~polv ^ (16'h1 << (10 * t));
			c0 = n_clr;
			r0 = n_rst;
			run <= 1'b1;
			wait_chg(n_irq, 120, c);
			check(falls, f + 2, "tamper samples");
			run <= 1'b0;
			level <= ~polv;
			repeat (2) @(posedge clk);
			check(n_clr - c0, t ? 0 : 1, "backup clear");
			check(n_rst - r0, 1, "tamper wake");
			bus(1'b0, `BWTC_OFS_SUPPLY_STATUS, 32'h0);
			check(q[15:0], 16'h1 << (13 + t), "tamper flag");
		end
		final_report();
	end
endmodule // tb_backup_wakeup_tamper_control
`default_nettype wire
